// ==== src/fcd_pkg.sv ====
// fcd_pkg: constants for the flash clock divider and security register bank
// assumes: 8-bit register port, 10 MHz bus clock
package fcd_pkg;
  localparam int FCD_ADDR_W = 4;
  localparam int FCD_DATA_W = 8;
  // register offsets
  localparam logic [3:0] FCD_OFS_DIV = 4'h0;
  localparam logic [3:0] FCD_OFS_SEC = 4'h1;
  // divider register fields
  localparam int FCD_BIT_WRITTEN = 7;
  localparam int FCD_BIT_LOCK = 6;
  localparam int FCD_DIV_MSB = 5;
  localparam int FCD_DIV_W = 6;
  localparam logic [5:0] FCD_DIV_RST = 6'h00;
  // security register fields
  localparam int FCD_KEY_MSB = 7;
  localparam int FCD_KEY_LSB = 6;
  localparam int FCD_SEC_MSB = 1;
  localparam int FCD_SEC_LSB = 0;
  localparam logic [1:0] FCD_KEY_ENABLED = 2'h2;
  localparam logic [1:0] FCD_SEC_UNSECURED = 2'h2;
  localparam logic [7:0] FCD_SEC_FAULT_VAL = 8'hFF;
  localparam logic [7:0] FCD_SEC_RST = 8'hFF;
  // timing
  localparam int FCD_CLK_HZ = 10000000;
  localparam int FCD_BASE_HZ = 1000000;
  localparam int FCD_CLK_MHZ = FCD_CLK_HZ / FCD_BASE_HZ;

  typedef enum logic [2:0] {
    FCD_ST_IDLE = 3'b001,
    FCD_ST_LOAD = 3'b010,
    FCD_ST_DONE = 3'b100
  } fcd_state_t;
endpackage

// ==== src/fcd_tick_if.sv ====
// fcd_tick_if: divider value and time base tick between the bank and its divider
// assumes: one clock domain
`timescale 1ns/1ps
interface fcd_tick_if;
  logic [5:0] div_value;
  logic tick;
  modport bank (output div_value, input tick);
  modport divider (input div_value, output tick);
endinterface

// ==== src/fcd_divider.sv ====
// fcd_divider: divides the bus clock by divider_value+1 into a one-cycle tick
// assumes: divider value steady while a flash command runs
`timescale 1ns/1ps
module fcd_divider (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  fcd_tick_if.divider tick_if
);
  import fcd_pkg::*;

  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic tick_r;
  wire logic wrap = (cnt_r >= tick_if.div_value);

  // counts 0..divider_value, so divider 0 gives a tick every cycle
  assign cnt_nxt = wrap ? 6'h00 : cnt_r + 6'h01;
  assign tick_if.tick = tick_r;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= 6'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= wrap;
    end
  end
endmodule // fcd_divider

// ==== src/fcd_bank.sv ====
// fcd_bank: flash clock divider register and flash security state register
// assumes: software keeps off the divider while a command runs; the nonvolatile
// security byte and its fault flag arrive with a one-cycle valid strobe
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps

// Function
// - bit 7 of the divider register reads 1 once it has been written since reset.
// - the lock bit can only go from 0 to 1 and freezes the divider field while set.
// - only reset clears the lock; writing zero to it does nothing.
// - the divider field divides the bus clock down to a nominal 1 MHz time base.
// - the divider accepts writes during the reset sequence although commands look busy.
// - the security register is readable and ignores every write.
// - the reset sequence loads the security register from the nonvolatile byte.
// - a double-bit fault on that load sets all security bits.
// - back-door key access is enabled only by key code 10.
// - only security code 10 means unsecured; all other codes mean secured.
// - a back-door unsecure forces the security field to read 10.
module fcd_bank (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [fcd_pkg::FCD_ADDR_W-1:0] i_addr,
  input wire logic [fcd_pkg::FCD_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_nv_valid,
  input wire logic [7:0] i_nv_sec_byte,
  input wire logic i_nv_dbl_fault,
  input wire logic i_backdoor_unsecure,
  output logic [fcd_pkg::FCD_DATA_W-1:0] o_rdata,
  output logic o_time_tick,
  output logic [5:0] o_divider_value,
  output logic o_backdoor_key_enabled,
  output logic o_unsecured,
  output logic o_sec_loaded
);
  import fcd_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fcd_tick_if tick_if ();
  fcd_state_t state_r;
  fcd_state_t state_nxt;
  logic written_r;
  logic lock_r;
  logic [5:0] div_r;
  logic [7:0] sec_r;
  logic bd_unsec_r;
  logic [7:0] rdata_r;
  logic tick_r;
  logic key_en_r;
  logic unsec_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic sel_div = (i_addr == FCD_OFS_DIV);
  wire logic sel_sec = (i_addr == FCD_OFS_SEC);
  // no command-busy gating here, so writes land during the reset sequence too
  wire logic div_wr = i_wr && sel_div;
  wire logic div_field_wr = div_wr && !lock_r;
  wire logic lock_nxt = lock_r | (div_wr & i_wdata[FCD_BIT_LOCK]);
  wire logic [1:0] sec_field_raw = sec_r[FCD_SEC_MSB:FCD_SEC_LSB];
  wire logic [1:0] sec_field = bd_unsec_r ? FCD_SEC_UNSECURED : sec_field_raw;
  wire logic [7:0] sec_view = {sec_r[7:2], sec_field};
  wire logic [7:0] div_view = {written_r, lock_r, div_r};
  wire logic [7:0] rd_mux = sel_div ? div_view : (sel_sec ? sec_view : 8'h00);
  wire logic load_take = (state_r == FCD_ST_LOAD) && i_nv_valid;
  wire logic [7:0] sec_load = i_nv_dbl_fault ? FCD_SEC_FAULT_VAL : i_nv_sec_byte;
  wire logic key_en_nxt = (sec_r[FCD_KEY_MSB:FCD_KEY_LSB] == FCD_KEY_ENABLED);
  wire logic unsec_nxt = (sec_field == FCD_SEC_UNSECURED);

  assign tick_if.div_value = div_r;

  fcd_divider u_div (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .tick_if(tick_if)
  );

  // ----------------------------------------------------------------
  // security load sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FCD_ST_IDLE: state_nxt = FCD_ST_LOAD;
      FCD_ST_LOAD: if (i_nv_valid) state_nxt = FCD_ST_DONE;
      FCD_ST_DONE: state_nxt = FCD_ST_DONE;
      default: state_nxt = FCD_ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= FCD_ST_IDLE;
      written_r <= 1'b0;
      lock_r <= 1'b0;
      div_r <= FCD_DIV_RST;
    end else begin
      state_r <= state_nxt;
      if (div_wr) written_r <= 1'b1;
      lock_r <= lock_nxt;
      if (div_field_wr) div_r <= i_wdata[FCD_DIV_MSB:0];
    end
  end

  // software writes never reach sec_r
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sec_r <= FCD_SEC_RST;
      bd_unsec_r <= 1'b0;
    end else begin
      if (load_take) sec_r <= sec_load;
      if (i_backdoor_unsecure) bd_unsec_r <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= 8'h00;
      tick_r <= 1'b0;
      key_en_r <= 1'b0;
      unsec_r <= 1'b0;
    end else begin
      rdata_r <= i_rd ? rd_mux : 8'h00;
      tick_r <= tick_if.tick;
      key_en_r <= key_en_nxt;
      unsec_r <= unsec_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_time_tick = tick_r;
  assign o_divider_value = div_r;
  assign o_backdoor_key_enabled = key_en_r;
  assign o_unsecured = unsec_r;
  // one-hot code: the done bit is itself a flip-flop, so the output needs no decode
  assign o_sec_loaded = state_r[2];
endmodule // fcd_bank

// ==== bench/fcd_bank_assertions.sv ====
// fcd_bank_assertions: port-level checks on the register bank
// assumes: bound to fcd_bank, single clock domain
`timescale 1ns/1ps
module fcd_bank_chk (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [fcd_pkg::FCD_ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_nv_valid,
  input wire logic [7:0] i_nv_sec_byte,
  input wire logic i_nv_dbl_fault,
  input wire logic i_backdoor_unsecure,
  input wire logic [7:0] o_rdata,
  input wire logic o_time_tick,
  input wire logic [5:0] o_divider_value,
  input wire logic o_backdoor_key_enabled,
  input wire logic o_unsecured,
  input wire logic o_sec_loaded
);
  import fcd_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  wire rd_div = i_rd && i_addr == FCD_OFS_DIV;
  wire d3 = o_divider_value == 6'h03;
  wire take = i_nv_valid && !o_sec_loaded;
  wire key_ok = !i_nv_dbl_fault && i_nv_sec_byte[7:6] == FCD_KEY_ENABLED;
  // --------------------------------------------------------------
  // read port and divider register
  // --------------------------------------------------------------
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  chk_written_flag: assert property (i_wr && i_addr == 4'h0 ##2 rd_div |=> o_rdata[7])
    else $error("written flag clear");
  chk_lock_freeze: assert property (rd_div ##1 o_rdata[6] |=> $stable(o_divider_value)[*8])
    else $error("divider moved while locked");
  chk_lock_sticky: assert property (rd_div ##1 o_rdata[6] ##1 rd_div |=> o_rdata[6])
    else $error("lock bit cleared");
  chk_div_readback: assert property (rd_div |=> o_rdata[5:0] == $past(o_divider_value))
    else $error("divider readback differs");
  chk_tick_period: assert property ($past(d3, 2) && $past(d3) && d3 && o_time_tick ##1 d3[*4]
    |-> o_time_tick && !$past(o_time_tick))
    else $error("tick period wrong");
  // --------------------------------------------------------------
  // security load and back door
  // --------------------------------------------------------------
  chk_key_load: assert property (take && $past(i_arst_n)
    |-> ##2 o_backdoor_key_enabled == $past(key_ok, 2))
    else $error("key enable after load wrong");
  chk_load_flag: assert property (take && $past(i_arst_n) |=> o_sec_loaded)
    else $error("load not taken");
  chk_backdoor_force: assert property (i_backdoor_unsecure && o_sec_loaded |-> ##2 o_unsecured[*4])
    else $error("back door did not unsecure");
endmodule // fcd_bank_chk

// ==== bench/fcd_bank_test.sv ====
// fcd_bank_test: directed register and security load sequences
// assumes: fcd_bank ports as declared, 10 MHz clock
`timescale 1ns/1ps
module fcd_bank_test;
  import fcd_pkg::*;
  logic i_mclk = 1'h0;
  logic i_arst_n = 1'h0;
  logic [FCD_ADDR_W-1:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, i_nv_sec_byte = 8'h00, o_rdata, b;
  logic i_wr = 1'h0, i_rd = 1'h0, i_nv_valid = 1'h0, i_nv_dbl_fault = 1'h0;
  logic i_backdoor_unsecure = 1'h0;
  logic o_time_tick, o_backdoor_key_enabled, o_unsecured, o_sec_loaded;
  logic [5:0] o_divider_value;
  int fail_count = 0, comparisons = 0, n;
  always #50 i_mclk = ~i_mclk;
  fcd_bank fcd_bank_i (.*);
  // --------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // no flash command is ever started here, so every divider write is legal
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'h0;
    #1 chk("rdata", o_rdata, e);
  endtask
  task automatic rst;
    i_arst_n <= 1'h0;
    i_backdoor_unsecure <= 1'h0;
    repeat (2) @(posedge i_mclk);
    i_arst_n <= 1'h1;
  endtask
  // load strobe waits past the first edge after release, then lets derived outputs settle
  task automatic nv(input logic [7:0] v, input logic f);
    repeat (2) @(posedge i_mclk);
    i_nv_valid <= 1'h1;
    i_nv_sec_byte <= v;
    i_nv_dbl_fault <= f;
    @(posedge i_mclk);
    i_nv_valid <= 1'h0;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  task automatic tk;
    n = 0;
    do begin
      @(posedge i_mclk);
      #1 n++;
    end while (!o_time_tick && n < 100);
    if (n == 100) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  initial begin
    rst();
    rd(4'h0, 8'h00);
    rd(4'h1, 8'hFF);
    wr(4'h0, 8'h03);
    rd(4'h0, 8'h83);
    tk();
    tk();
    chk("period", n[7:0], 8'h04);
    wr(4'h0, 8'h45);
    wr(4'h0, 8'h0A);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'hC5);
    rd(4'h0, 8'hC5);
    rd(4'h7, 8'h00);
    rst();
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h05);
    rd(4'h0, 8'h85);
    wr(4'h0, 8'h09);
    tk();
    tk();
    tk();
    chk("period", n[7:0], 8'h0A);
    for (int i = 0; i < 5; i++) begin
      rst();
      b = (i < 4) ? {i[1:0], 4'hF, i[1:0]} : 8'h82;
      nv(b, i == 4);
      chk("key", {7'h00, o_backdoor_key_enabled}, {7'h00, i == 2});
      chk("unsec", {7'h00, o_unsecured}, {7'h00, i == 2});
      rd(4'h1, (i < 4) ? b : 8'hFF);
    end
    wr(4'h1, 8'h00);
    rd(4'h1, 8'hFF);
    @(posedge i_mclk);
    i_backdoor_unsecure <= 1'h1;
    @(posedge i_mclk);
    i_backdoor_unsecure <= 1'h0;
    rd(4'h1, 8'hFE);
    chk("unsec", {7'h00, o_unsecured}, 8'h01);
    tally_and_finish();
  end
endmodule // fcd_bank_test
bind fcd_bank fcd_bank_chk fcd_bank_chk_i (.*);
